// *** verilog/hps_pkg.sv ***
// Shared types and constants for the host path switch
package hps_pkg;

  // Width of one in-band data byte
  localparam int unsigned DATA_W = 8;

  // Stages in every level synchroniser
  localparam int unsigned SYNC_STAGES = 2;

  // One beat on any host path: a packet byte or an in-band message byte
  typedef struct packed {
    logic              msg;   // High: in-band message (toward host) or its acknowledge (from host)
    logic              last;  // High on the final byte of a packet
    logic [DATA_W-1:0] data;  // Payload byte
  } hps_word_t;

  localparam int unsigned WORD_W = $bits(hps_word_t);

  // Reset value of a beat register
  localparam hps_word_t WORD_RESET = '{msg: 1'b0, last: 1'b0, data: 8'h00};

  // Line side conditions that force the fast link quiet in the active state
  typedef struct packed {
    logic power_down;  // Transceiver powered down
    logic idle;        // Transceiver idle
    logic disconnect;  // Cable disconnected
    logic lpi;         // Low Power Idle on the line
  } hps_line_stat_t;

  // Reset values of the path controls
  localparam logic SPEED_LIMIT_RESET = 1'b1;
  localparam logic FAST_DOWN_RESET   = 1'b1;
  localparam logic FAST_QUIET_RESET  = 1'b1;

endpackage

// *** verilog/hps_sync.sv ***
// Two flip-flop level synchroniser, one lane per bit
`timescale 1ns/1ps
module hps_sync #(
  parameter int unsigned W = 1
) (
  input  wire logic         clk,     // Destination clock
  input  wire logic         resetn,  // Asynchronous reset, active low
  input  wire logic [W-1:0] d,       // Level from another domain
  output logic      [W-1:0] q        // Level safe for this domain
);

  logic [W-1:0] meta_q;

  // First stage feeds only the second stage
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      meta_q <= '0;
      q      <= '0;
    end else begin
      meta_q <= d;
      q      <= meta_q;
    end
  end

endmodule

// *** verilog/hps_word_cdc.sv ***
// Toggle handshake carrying one word at a time between two clock domains
`timescale 1ns/1ps
module hps_word_cdc #(
  parameter int unsigned W = 10
) (
  input  wire logic         src_clk,     // Source clock
  input  wire logic         src_resetn,  // Source reset, active low
  input  wire logic         src_valid,   // Source offers a word
  input  wire logic [W-1:0] src_data,    // Offered word
  output logic              src_ready,   // Word taken this cycle when valid
  input  wire logic         dst_clk,     // Destination clock
  input  wire logic         dst_resetn,  // Destination reset, active low
  output logic              dst_valid,   // Word waiting at destination
  output logic      [W-1:0] dst_data,    // Waiting word
  input  wire logic         dst_ready    // Destination takes the word
);

  logic         req_q;
  logic [W-1:0] hold_q;
  logic         ack_q;
  logic         seen_q;
  logic         req_s;
  logic         ack_s;

  // One word in flight; held stable until the far side toggles back
  assign src_ready = (req_q == ack_s);

  always_ff @(posedge src_clk or negedge src_resetn) begin
    if (!src_resetn) begin
      req_q  <= 1'b0;
      hold_q <= '0;
    end else if (src_valid && src_ready) begin
      req_q  <= ~req_q;
      hold_q <= src_data;
    end
  end

  hps_sync #(.W(1)) u_req_sync (
    .clk    (dst_clk),
    .resetn (dst_resetn),
    .d      (req_q),
    .q      (req_s)
  );

  hps_sync #(.W(1)) u_ack_sync (
    .clk    (src_clk),
    .resetn (src_resetn),
    .d      (ack_q),
    .q      (ack_s)
  );

  // New toggle captures the held word; acknowledge when consumed
  always_ff @(posedge dst_clk or negedge dst_resetn) begin
    if (!dst_resetn) begin
      seen_q    <= 1'b0;
      ack_q     <= 1'b0;
      dst_valid <= 1'b0;
      dst_data  <= '0;
    end else begin
      if (dst_valid && dst_ready) begin
        dst_valid <= 1'b0;
        ack_q     <= seen_q;
      end
      if (req_s != seen_q) begin
        seen_q    <= req_s;
        dst_valid <= 1'b1;
        dst_data  <= hold_q;
      end
    end
  end

endmodule

// *** verilog/hps_path_switch.sv ***
// Chooses fast serial link or management bus for in-band host traffic
`timescale 1ns/1ps
module hps_path_switch (
  input  wire logic               core_clk,           // Core clock, 125 MHz
  input  wire logic               resetn,             // Asynchronous reset, active low
  input  wire logic               host_power_good_n,  // Host power-good pin, high when good
  input  wire hps_pkg::hps_line_stat_t line_stat,     // Line side conditions
  output logic                    speed_limit_10m,    // Restrict line to 10 Mbps
  input  wire logic               up_valid,           // Packet byte toward host valid
  input  wire hps_pkg::hps_word_t up_word,            // Packet byte toward host
  output logic                    up_ready,           // Packet byte taken or dropped
  output logic                    down_valid,         // Packet byte from host valid
  output hps_pkg::hps_word_t      down_word,          // Packet byte from host
  output logic                    down_abort,         // Packet from host cut by a switch
  input  wire logic               msg_valid,          // In-band message to send
  input  wire logic [hps_pkg::DATA_W-1:0] msg_data,   // Message byte
  output logic                    msg_ready,          // Message accepted
  output logic                    msg_done,           // Message acknowledged by host
  output logic                    mb_tx_valid,        // Byte toward management bus engine
  output hps_pkg::hps_word_t      mb_tx_word,         // Byte toward management bus engine
  input  wire logic               mb_tx_ready,        // Management bus engine takes byte
  input  wire logic               mb_rx_valid,        // Byte from management bus engine
  input  wire hps_pkg::hps_word_t mb_rx_word,         // Byte from management bus engine
  input  wire logic               fast_link_clk,      // Fast link clock
  output logic                    fl_tx_valid,        // Byte toward fast link valid
  output hps_pkg::hps_word_t      fl_tx_word,         // Byte toward fast link
  input  wire logic               fl_tx_ready,        // Fast link takes byte
  input  wire logic               fl_rx_valid,        // Byte from fast link valid
  input  wire hps_pkg::hps_word_t fl_rx_word,         // Byte from fast link
  output logic                    fl_rx_ready,        // Fast link byte taken
  output logic                    line_quiet_state,   // Fast link held in quiet line state
  output logic                    fl_power_down       // Fast link powered down
);

  typedef enum logic [1:0] {ST_MGMT, ST_FAST, ST_DRAIN} hps_path_t;

  hps_path_t          path_q;
  logic               pg_act;
  logic               link_resetn;
  logic               tx_in_pkt_q;
  logic               rx_in_pkt_q;
  logic               drop_q;
  logic               msg_pend_q;
  logic               msg_sent_q;
  logic [hps_pkg::DATA_W-1:0] msg_q;
  logic               quiet_q;
  logic               fdown_q;
  logic               fsrc_valid;
  logic               fsrc_ready;
  hps_pkg::hps_word_t tx_word;
  logic               send_msg;
  logic               fast_ok;
  logic               sink_ready;
  logic               rx_valid;
  hps_pkg::hps_word_t rx_word;
  logic               frx_valid;
  hps_pkg::hps_word_t frx_word;
  logic               drain_done;
  logic [1:0]         link_ctl;
  logic               pkt_open;

  // synchronise power-good; the pin is from another domain
  hps_sync #(.W(1)) u_pg_sync (
    .clk    (core_clk),
    .resetn (resetn),
    .d      (host_power_good_n),
    .q      (pg_act)
  );

  // Link side reset: asserts at once, releases on the link clock
  hps_sync #(.W(1)) u_link_rst (
    .clk    (fast_link_clk),
    .resetn (resetn),
    .d      (1'b1),
    .q      (link_resetn)
  );

  // Drain ends once the cut packet is swallowed and no fast word is in flight
  assign drain_done = !drop_q && !(up_valid && tx_in_pkt_q) && fsrc_ready;

  // A byte taken on the switching edge decides whether a packet stays open
  assign pkt_open   = (up_valid && up_ready) ? !up_word.last : tx_in_pkt_q;

  // path follows power-good, through a drain step
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      path_q <= ST_MGMT;
    end else begin
      unique case (path_q)
        ST_MGMT: if (pg_act) path_q <= ST_DRAIN;
        ST_FAST: if (!pg_act) path_q <= ST_DRAIN;
        ST_DRAIN: begin
          if (drain_done) begin
            path_q <= pg_act ? ST_FAST : ST_MGMT;
          end
        end
      endcase
    end
  end

  // a packet cut by the switch is swallowed to its last byte
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      drop_q <= 1'b0;
    end else if (path_q != ST_DRAIN && (pg_act != (path_q == ST_FAST)) && pkt_open) begin
      drop_q <= 1'b1;
    end else if (drop_q && up_valid && up_word.last) begin
      drop_q <= 1'b0;
    end
  end

  // quiet while active but line asleep; power down in sleep
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      quiet_q         <= hps_pkg::FAST_QUIET_RESET;
      fdown_q         <= hps_pkg::FAST_DOWN_RESET;
      speed_limit_10m <= hps_pkg::SPEED_LIMIT_RESET;
    end else begin
      quiet_q         <= pg_act && (|line_stat);
      fdown_q         <= !pg_act;
      // speed cap unless the fast link is the chosen path
      speed_limit_10m <= (path_q != ST_FAST);
    end
  end

  // fast link carries everything only while live
  assign fast_ok    = (path_q == ST_FAST) && !quiet_q;
  assign sink_ready = (path_q == ST_FAST) ? (fast_ok && fsrc_ready) : mb_tx_ready;

  // Messages go only between packets so a packet is never split
  assign send_msg = msg_pend_q && !msg_sent_q && !tx_in_pkt_q && (path_q != ST_DRAIN);
  always_comb begin
    tx_word = up_word;
    if (send_msg) begin
      tx_word = '{msg: 1'b1, last: 1'b1, data: msg_q};
    end
  end

  // Drain swallows cut bytes; elsewhere the chosen path sets the pace
  assign up_ready    = drop_q || (path_q != ST_DRAIN && !send_msg && sink_ready);
  // management bus used only when it is the path
  assign mb_tx_valid = (path_q == ST_MGMT) && (send_msg || up_valid);
  assign mb_tx_word  = tx_word;
  assign fsrc_valid  = fast_ok && (send_msg || up_valid);

  // Track whether a packet toward host has begun
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      tx_in_pkt_q <= 1'b0;
    end else if (up_valid && up_ready) begin
      tx_in_pkt_q <= !up_word.last;
    end
  end

  // message held until acknowledged; a switch re-arms it
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      msg_pend_q <= 1'b0;
      msg_sent_q <= 1'b0;
      msg_q      <= '0;
      msg_done   <= 1'b0;
    end else begin
      msg_done <= 1'b0;
      if (rx_valid && rx_word.msg && msg_pend_q && msg_sent_q) begin
        msg_pend_q <= 1'b0;
        msg_sent_q <= 1'b0;
        msg_done   <= 1'b1;
      end else if (path_q == ST_DRAIN) begin
        msg_sent_q <= 1'b0;
      end else if (send_msg && sink_ready) begin
        msg_sent_q <= 1'b1;
      end
      if (msg_valid && msg_ready) begin
        msg_pend_q <= 1'b1;
        msg_q      <= msg_data;
      end
    end
  end
  assign msg_ready = !msg_pend_q;

  // Receive from the chosen path; the other path is drained and discarded
  assign rx_valid = (path_q == ST_FAST) ? frx_valid : (path_q == ST_MGMT) && mb_rx_valid;
  assign rx_word  = (path_q == ST_FAST) ? frx_word : mb_rx_word;

  // incomplete packet from host is cut with an abort pulse
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      rx_in_pkt_q <= 1'b0;
      down_valid  <= 1'b0;
      down_word   <= hps_pkg::WORD_RESET;
      down_abort  <= 1'b0;
    end else begin
      down_valid <= rx_valid && !rx_word.msg;
      down_abort <= 1'b0;
      if (rx_valid && !rx_word.msg) begin
        down_word   <= rx_word;
        rx_in_pkt_q <= !rx_word.last;
      end else if (path_q == ST_DRAIN && rx_in_pkt_q) begin
        rx_in_pkt_q <= 1'b0;
        down_abort  <= 1'b1;
      end
    end
  end

  // Words toward the fast link cross to its clock
  hps_word_cdc #(.W(hps_pkg::WORD_W)) u_tx_cdc (
    .src_clk    (core_clk),
    .src_resetn (resetn),
    .src_valid  (fsrc_valid),
    .src_data   (tx_word),
    .src_ready  (fsrc_ready),
    .dst_clk    (fast_link_clk),
    .dst_resetn (link_resetn),
    .dst_valid  (fl_tx_valid),
    .dst_data   (fl_tx_word),
    .dst_ready  (fl_tx_ready)
  );

  // Words from the fast link cross to the core; always consumed
  hps_word_cdc #(.W(hps_pkg::WORD_W)) u_rx_cdc (
    .src_clk    (fast_link_clk),
    .src_resetn (link_resetn),
    .src_valid  (fl_rx_valid),
    .src_data   (fl_rx_word),
    .src_ready  (fl_rx_ready),
    .dst_clk    (core_clk),
    .dst_resetn (resetn),
    .dst_valid  (frx_valid),
    .dst_data   (frx_word),
    .dst_ready  (1'b1)
  );

  // Quiet and power-down levels cross into the link domain
  hps_sync #(.W(2)) u_ctl_sync (
    .clk    (fast_link_clk),
    .resetn (link_resetn),
    .d      ({quiet_q, fdown_q}),
    .q      (link_ctl)
  );
  // Reset shows quiet and powered down; both read low for two link cycles after link reset releases, until the core levels arrive
  assign line_quiet_state = link_ctl[1] || !link_resetn;
  assign fl_power_down    = link_ctl[0] || !link_resetn;

  // Checks on the path choice
  a_fast_leaves_mgmt: assert property (@(posedge core_clk) disable iff (!resetn)
    (path_q == ST_MGMT && pg_act) |=> path_q == ST_DRAIN)
    else $error("power-good high did not leave management path");
  a_mgmt_leaves_fast: assert property (@(posedge core_clk) disable iff (!resetn)
    (path_q == ST_FAST && !pg_act) |=> path_q == ST_DRAIN)
    else $error("power-good low did not leave fast path");
  a_mgmt_idle_fast: assert property (@(posedge core_clk) disable iff (!resetn)
    path_q == ST_FAST |-> !mb_tx_valid)
    else $error("management bus used on fast path");
  a_sleep_no_fast: assert property (@(posedge core_clk) disable iff (!resetn)
    (!pg_act && path_q == ST_MGMT) |=> fdown_q && !fsrc_valid)
    else $error("fast link active in sleep");
  a_quiet_lpi_hold: assert property (@(posedge core_clk) disable iff (!resetn)
    (pg_act && line_stat.lpi) ##1 (path_q == ST_FAST) |-> quiet_q && !fsrc_valid)
    else $error("fast link not quiet in low power idle");
  a_quiet_idle_hold: assert property (@(posedge core_clk) disable iff (!resetn)
    (pg_act && (line_stat.idle || line_stat.disconnect || line_stat.power_down)) |=> quiet_q)
    else $error("fast link not quiet while line is down");
  a_drain_no_tx: assert property (@(posedge core_clk) disable iff (!resetn)
    path_q == ST_DRAIN |-> !mb_tx_valid && !fsrc_valid)
    else $error("traffic sent during path switch");
  a_cut_swallowed: assert property (@(posedge core_clk) disable iff (!resetn)
    (drop_q && up_valid) |-> up_ready && !mb_tx_valid && !fsrc_valid)
    else $error("cut packet not dropped");
  a_msg_rearmed: assert property (@(posedge core_clk) disable iff (!resetn)
    (path_q == ST_DRAIN && msg_pend_q && !msg_done) ##1 (path_q != ST_DRAIN) |-> !msg_sent_q)
    else $error("pending message not resent after switch");
  a_speed_cap: assert property (@(posedge core_clk) disable iff (!resetn)
    (path_q == ST_MGMT) ##1 (path_q == ST_MGMT) |-> speed_limit_10m)
    else $error("line speed not limited on management path");
  a_abort_single: assert property (@(posedge core_clk) disable iff (!resetn)
    down_abort |=> !down_abort [*2])
    else $error("abort pulse too long");

  // Checks on dropping, resending and the speed cap
  a_drop_to_fast: assert property (@(posedge core_clk) disable iff (!resetn)
    (path_q == ST_MGMT && pg_act && pkt_open) |=> drop_q)
    else $error("open packet not dropped on switch to fast link");
  a_drop_to_mgmt: assert property (@(posedge core_clk) disable iff (!resetn)
    (path_q == ST_FAST && !pg_act && pkt_open) |=> drop_q)
    else $error("open packet not dropped on switch to management bus");
  a_drop_ends: assert property (@(posedge core_clk) disable iff (!resetn)
    (drop_q && up_valid && up_word.last) |=> !drop_q)
    else $error("dropping went past the last byte");
  a_rx_cut_abort: assert property (@(posedge core_clk) disable iff (!resetn)
    (path_q == ST_DRAIN && rx_in_pkt_q) |=> down_abort)
    else $error("open packet from host not aborted");
  a_drain_holds_up: assert property (@(posedge core_clk) disable iff (!resetn)
    (path_q == ST_DRAIN && !drop_q) |-> !up_ready)
    else $error("byte taken during switch");
  a_one_path_tx: assert property (@(posedge core_clk) disable iff (!resetn)
    !(mb_tx_valid && fsrc_valid))
    else $error("both paths carry traffic");
  a_msg_between_pkts: assert property (@(posedge core_clk) disable iff (!resetn)
    (mb_tx_valid && mb_tx_word.msg) |-> !tx_in_pkt_q)
    else $error("message split a packet");
  a_speed_free_fast: assert property (@(posedge core_clk) disable iff (!resetn)
    (path_q == ST_FAST) ##1 (path_q == ST_FAST) |-> !speed_limit_10m)
    else $error("line speed limited on fast path");
  a_done_single: assert property (@(posedge core_clk) disable iff (!resetn)
    msg_done |-> msg_ready ##1 !msg_done)
    else $error("message done pulse wrong");
  a_resend_fast: assert property (@(posedge core_clk) disable iff (!resetn)
    (path_q == ST_FAST && msg_pend_q && !msg_sent_q && !tx_in_pkt_q && !quiet_q && fsrc_ready)
    |-> fsrc_valid && !up_ready)
    else $error("pending message not offered to fast link");
  a_resend_mgmt: assert property (@(posedge core_clk) disable iff (!resetn)
    (path_q == ST_MGMT && msg_pend_q && !msg_sent_q && !tx_in_pkt_q)
    |-> mb_tx_valid && mb_tx_word.msg)
    else $error("pending message not offered to management bus");
  a_fast_carries: assert property (@(posedge core_clk) disable iff (!resetn)
    (path_q == ST_FAST && !quiet_q && up_valid && !send_msg) |-> fsrc_valid)
    else $error("fast link did not carry packet byte");
  a_rx_sleep_only_mb: assert property (@(posedge core_clk) disable iff (!resetn)
    (path_q != ST_FAST && !mb_rx_valid) |=> !down_valid)
    else $error("byte from unselected path passed on");

  c_to_fast: cover property (@(posedge core_clk) disable iff (!resetn)
    path_q == ST_DRAIN ##1 path_q == ST_FAST);
  c_to_mgmt: cover property (@(posedge core_clk) disable iff (!resetn)
    path_q == ST_DRAIN ##1 path_q == ST_MGMT);
  c_msg_resent: cover property (@(posedge core_clk) disable iff (!resetn)
    (path_q == ST_DRAIN && msg_pend_q) ##[1:50] msg_done);
  c_rx_abort: cover property (@(posedge core_clk) disable iff (!resetn) down_abort);
  c_pkt_cut: cover property (@(posedge core_clk) disable iff (!resetn)
    drop_q && up_valid && up_word.last);

endmodule

// *** tb/hps_mac_model.sv ***
// Behavioural fast link end of the host MAC for the bench
`timescale 1ns/1ps
module hps_mac_model (
  input  wire logic               fast_link_clk,  // Link clock
  input  wire logic               fl_tx_valid,    // Byte from block valid
  input  wire hps_pkg::hps_word_t fl_tx_word,     // Byte from block
  output logic                    fl_tx_ready,    // Model takes byte
  output logic                    fl_rx_valid,    // Byte toward block valid
  output hps_pkg::hps_word_t      fl_rx_word,     // Byte toward block
  input  wire logic               fl_rx_ready,    // Block takes byte
  input  wire logic               slow,           // Stall every other link cycle
  input  wire logic               ack_en          // Acknowledge messages
);
  hps_pkg::hps_word_t tx_q[$];
  hps_pkg::hps_word_t rx_q[$];
  logic               ph;

  // Idle outputs at time zero
  initial begin
    fl_tx_ready = 1'b0;
    fl_rx_valid = 1'b0;
    fl_rx_word  = '0;
    ph          = 1'b0;
  end

  always @(posedge fast_link_clk) begin
    if (fl_tx_valid && fl_tx_ready) begin
      tx_q.push_back(fl_tx_word);
      if (fl_tx_word.msg && ack_en)
        rx_q.push_back('{msg: 1'b1, last: 1'b1, data: fl_tx_word.data});
    end
    ph          <= ~ph;
    fl_tx_ready <= #1 ~slow | ph;
  end

  // Hold each byte until taken; a released line shows the inverse so stale data never matches
  always @(posedge fast_link_clk) begin
    if (fl_rx_valid && fl_rx_ready) begin
      fl_rx_valid <= #1 1'b0;
      fl_rx_word  <= #1 ~fl_rx_word;
    end else if (!fl_rx_valid && rx_q.size() > 0) begin
      fl_rx_valid <= #1 1'b1;
      fl_rx_word  <= #1 rx_q.pop_front();
    end
  end
endmodule

// *** tb/hps_path_switch_bench.sv ***
// Self-checking bench for the host path switch
`timescale 1ns/1ps
module hps_path_switch_bench;
  logic core_clk, resetn, fast_link_clk, pg, sl10, upv, upr, dnv, dna, mv, mr, mdn;
  logic mbtv, mbtr, mbrv, fltv, fltr, flrv, flrr, quiet, fpd, slow, ack_en;
  logic [7:0]             md;
  hps_pkg::hps_line_stat_t ls;
  hps_pkg::hps_word_t     upw, dnw, mbtw, mbrw, fltw, flrw;
  hps_pkg::hps_word_t     mb_q[$], dn_q[$];
  int err_count, compares, aborts, dones, cycles;

  hps_path_switch dut (.core_clk(core_clk), .resetn(resetn), .host_power_good_n(pg), .line_stat(ls),
    .speed_limit_10m(sl10), .up_valid(upv), .up_word(upw), .up_ready(upr), .down_valid(dnv),
    .down_word(dnw), .down_abort(dna), .msg_valid(mv), .msg_data(md), .msg_ready(mr), .msg_done(mdn),
    .mb_tx_valid(mbtv), .mb_tx_word(mbtw), .mb_tx_ready(mbtr), .mb_rx_valid(mbrv), .mb_rx_word(mbrw),
    .fast_link_clk(fast_link_clk), .fl_tx_valid(fltv), .fl_tx_word(fltw), .fl_tx_ready(fltr),
    .fl_rx_valid(flrv), .fl_rx_word(flrw), .fl_rx_ready(flrr), .line_quiet_state(quiet),
    .fl_power_down(fpd));
  hps_mac_model mac (.fast_link_clk(fast_link_clk), .fl_tx_valid(fltv), .fl_tx_word(fltw),
    .fl_tx_ready(fltr), .fl_rx_valid(flrv), .fl_rx_word(flrw), .fl_rx_ready(flrr), .slow(slow),
    .ack_en(ack_en));

  // Core clock 8 ns, link clock 12 ns with an unrelated phase
  initial begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end
  initial begin
    fast_link_clk = 1'b0;
    #3.3;
    forever #6 fast_link_clk = ~fast_link_clk;
  end

  // Watch outputs at the edge; the cycle ceiling cuts a hang short
  always @(posedge core_clk) begin
    if (mbtv && mbtr) mb_q.push_back(mbtw);
    if (dnv) dn_q.push_back(dnw);
    if (dna) aborts++;
    if (mdn) dones++;
    cycles++;
    if (cycles == 30000) begin
      err_count++;
      give_verdict();
    end
  end

  task chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
    compares++;
    if (seen !== exp) begin
      err_count++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task tick(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask

  // Valid held until ready is seen at an edge; a cut packet leaves last low
  task send_pkt(input logic [7:0] base, input int n, input logic cut);
    int i;
    upv = 1'b1;
    for (int k = 0; k < n; k++) begin
      upw = '{msg: 1'b0, last: (k == n - 1) && !cut, data: base + 8'(k)};
      #1;
      for (i = 0; i < 300 && upr !== 1'b1; i++) begin
        @(posedge core_clk);
        #2;
      end
      @(posedge core_clk);
      #1;
    end
    upv = 1'b0;
  endtask

  // Management engine bytes from host, no backpressure
  task mb_rx(input logic [7:0] base, input int n, input logic cut, input logic m);
    mbrv = 1'b1;
    for (int k = 0; k < n; k++) begin
      mbrw = '{msg: m, last: (k == n - 1) && !cut, data: base + 8'(k)};
      tick(1);
    end
    mbrv = 1'b0;
    mbrw = ~mbrw;
  endtask

  task send_msg(input logic [7:0] d);
    int i;
    mv = 1'b1;
    md = d;
    #1;
    for (i = 0; i < 300 && mr !== 1'b1; i++) begin
      @(posedge core_clk);
      #2;
    end
    @(posedge core_clk);
    #1;
    mv = 1'b0;
  endtask

  task t_mgmt;
    send_pkt(8'h10, 3, 1'b0);
    tick(4);
    chk("mb count", 8'(mb_q.size()), 8'h03);
    chk("mb last", {mb_q[2].last, mb_q[2].data[6:0]}, 8'h92);
    chk("fast idle", 8'(mac.tx_q.size()), 8'h00);
    mb_rx(8'h20, 2, 1'b0, 1'b0);
    tick(3);
    chk("down data", dn_q[1].data, 8'h21);
    mb_q.delete();
  endtask

  task t_rise;
    int i;
    send_msg(8'h5A);
    mb_rx(8'h30, 2, 1'b1, 1'b0);
    tick(5);
    chk("mb msg", {mb_q[0].msg, mb_q[0].data[6:0]}, 8'hDA);
    pg = 1'b1;
    for (i = 0; i < 300 && dones == 0; i++) tick(1);
    chk("speed", sl10, 1'b0);
    chk("abort", 8'(aborts), 8'h01);
    chk("done", 8'(dones), 8'h01);
    chk("resend", mac.tx_q[0].data, 8'h5A);
    chk("awake", {quiet, fpd}, 8'h00);
    mac.tx_q.delete();
    dn_q.delete();
    mb_q.delete();
  endtask

  task t_fast;
    send_pkt(8'h40, 4, 1'b0);
    mac.rx_q.push_back('{msg: 1'b0, last: 1'b0, data: 8'h50});
    mac.rx_q.push_back('{msg: 1'b0, last: 1'b1, data: 8'h51});
    tick(100);
    chk("fast count", 8'(mac.tx_q.size()), 8'h04);
    chk("fast last", {mac.tx_q[3].last, mac.tx_q[3].data[6:0]}, 8'hC3);
    chk("mb unused", 8'(mb_q.size()), 8'h00);
    chk("fast down", dn_q[1].data, 8'h51);
  endtask

  task t_quiet;
    for (int b = 0; b < 4; b++) begin
      ls = hps_pkg::hps_line_stat_t'(4'h1 << b);
      tick(20);
      chk("quiet", quiet, 1'b1);
      ls = '0;
      tick(20);
      chk("unquiet", quiet, 1'b0);
    end
  endtask

  task t_fall;
    int i;
    ack_en = 1'b0;
    mac.tx_q.delete();
    send_msg(8'hA5);
    tick(60);
    chk("busy", mr, 1'b0);
    send_pkt(8'h60, 2, 1'b1);
    mac.rx_q.push_back('{msg: 1'b0, last: 1'b0, data: 8'h70});
    tick(60);
    pg = 1'b0;
    for (i = 0; i < 300 && sl10 !== 1'b1; i++) tick(1);
    send_pkt(8'h62, 2, 1'b0);
    tick(10);
    chk("abort2", 8'(aborts), 8'h02);
    chk("mb resend", {mb_q[0].msg, mb_q[0].data[6:0]}, 8'hA5);
    chk("swallow", 8'(mb_q.size()), 8'h01);
    chk("fast stop", 8'(mac.tx_q.size()), 8'h03);
    mb_rx(8'hA5, 1, 1'b0, 1'b1);
    tick(3);
    chk("done2", 8'(dones), 8'h02);
    chk("free", mr, 1'b1);
    chk("sleep", {sl10, fpd}, 8'h03);
  endtask

  task give_verdict;
    $display("compares %0d err_count %0d", compares, err_count);
    if (err_count == 0 && compares > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  // Reset for 20 cycles, then run each scenario
  initial begin
    {resetn, pg, upv, mv, mbrv, slow} = '0;
    {err_count, compares, aborts, dones, cycles} = '0;
    {md, upw, mbrw, ls} = '0;
    mbtr   = 1'b1;
    ack_en = 1'b1;
    repeat (20) @(posedge core_clk);
    #1;
    resetn = 1'b1;
    chk("reset", {sl10, quiet, fpd, dnv}, 8'h0E);
    tick(5);
    t_mgmt();
    t_rise();
    slow = 1'b1;
    t_fast();
    t_quiet();
    t_fall();
    give_verdict();
  end
endmodule
